// ==== hw/otpcfg_consts.svh ====
// Constants for the OTP configuration and InfoPage control block
// Notes on behaviour
// R1: MCU data addresses 0xFC00-0xFFFF map onto the 1 kB non-volatile data area.
// R2: The non-volatile data area sits at physical array addresses 0x4400-0x47FF.
// R3: MCU software keeps the program-write select clear and uses data addresses.
// R4: Each reset loads configuration bytes from the info page into the status register.
// R5: Array is 16 kB code plus 1 kB data main block, plus 512-byte info page.
// R6: Programmer leaves the 32-byte device system area at offset 0x00 untouched.
// R7: Programmer keeps reserved bytes at 0x20 and 0x24 at 0xFF; last 256 are user.
// R8: Byte 0x23 equal 0xFF allows external main access; else only info page reads.
// R9: Programmer sets the protect byte once, by its own command, as last command.
// R10: One status register at special-function address 0xF8 serves SPI and MCU.
// R11: Write latch bit 5 resets 0, enables SPI writes, clears after SPI writes only.
// R12: Bit 4 is read-only active-low ready, reset 1, cleared when boot readout ends.
// R13: Bit 3 redirects SPI reads and writes to info page; resets 0; both write it.
// R14: Bit 2 reads 1 until loaded; 1 blocks SPI main access and info page writes.
// R15: Generic status write never changes the write latch or protect bits.
// R16: All configuration is done by the external party through info page updates.
// R17: MCU reaches code and data storage through ordinary code and data accesses.
// R18: Command 0x85 enables readback protection, accepted only with write latch set.
// R19: Command 0x06 sets the write latch and command 0x04 clears it.
// R20: Protection counts as active until the boot readout has completed.
`ifndef OTPCFG_CONSTS_SVH
`define OTPCFG_CONSTS_SVH

// ==========================================
// Register address and bit positions
`define OTPCFG_STATUS_ADDR   8'hF8
`define OTPCFG_BIT_WEN       5
`define OTPCFG_BIT_READY_LOW_FLAG      4
`define OTPCFG_BIT_REDIR     3
`define OTPCFG_BIT_RBD       2
`define OTPCFG_BIT_RSV1      1
`define OTPCFG_BIT_RSV0      0

// ==========================================
// Memory map
`define OTPCFG_NV_XDATA_BASE 16'hFC00
`define OTPCFG_NV_PHYS_BASE  15'h4400
`define OTPCFG_MAIN_LIMIT    15'h4800
`define OTPCFG_IP_RBD_OFS    15'h0023
`define OTPCFG_RBD_OPEN      8'hFF
`define OTPCFG_RBD_CLOSED    8'h00

// ==========================================
// SPI command bytes
`define OTPCFG_CMD_LATCH_SET   8'h06
`define OTPCFG_CMD_LATCH_CLEAR 8'h04
`define OTPCFG_CMD_STAT_READ   8'h05
`define OTPCFG_CMD_STAT_WRITE  8'h01
`define OTPCFG_CMD_READ        8'h03
`define OTPCFG_CMD_PROGRAM     8'h02
`define OTPCFG_CMD_RBD         8'h85

`endif

// ==== hw/otpcfg_pkg.sv ====
// Types shared by the OTP configuration block
package otpcfg_pkg;
  typedef enum logic [2:0] {
    OTPCFG_BOOT_REQ,
    OTPCFG_BOOT_WAIT,
    OTPCFG_IDLE,
    OTPCFG_SPI_WAIT,
    OTPCFG_RBD_WAIT,
    OTPCFG_MCU_WAIT
  } otpcfg_state_type;

  // One request to the OTP array
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        info;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } otpcfg_arr_req_type;
endpackage

// ==== hw/otpcfg_addr_map.sv ====
// Address mapping from MCU and SPI address spaces to OTP array addresses
`timescale 1ns/1ps
`default_nettype none
`include "otpcfg_consts.svh"
module otpcfg_addr_map (
  // MCU side
  input  wire logic [15:0] mcu_addr_i,
  input  wire logic        mcu_code_i,
  // SPI side
  input  wire logic [15:0] spi_addr_i,
  // Results
  output logic             mcu_hit_o,
  output logic [14:0]      mcu_phys_o,
  output logic             spi_main_ok_o,
  output logic [14:0]      spi_phys_o
);
  always_comb begin
    if (mcu_code_i) begin
      // 16 kB code space sits at the bottom of the main block
      mcu_hit_o  = (mcu_addr_i[15:14] == 2'b00); // R17
      mcu_phys_o = {1'b0, mcu_addr_i[13:0]};
    end else begin
      mcu_hit_o  = (mcu_addr_i >= `OTPCFG_NV_XDATA_BASE); // R1
      mcu_phys_o = `OTPCFG_NV_PHYS_BASE | {5'h00, mcu_addr_i[9:0]}; // R2
    end
    spi_phys_o    = spi_addr_i[14:0];
    spi_main_ok_o = (spi_addr_i[15] == 1'b0) && (spi_addr_i[14:0] < `OTPCFG_MAIN_LIMIT); // R5
  end
endmodule
`default_nettype wire

// ==== hw/otpcfg_ctrl.sv ====
// OTP configuration, status register and access control
`timescale 1ns/1ps
`default_nettype none
`include "otpcfg_consts.svh"
module otpcfg_ctrl (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  resetn_i,
  // Special-function register port from the MCU
  input  wire logic [7:0]            sfr_addr_i,
  input  wire logic                  sfr_wr_i,
  input  wire logic [7:0]            sfr_wdata_i,
  output logic [7:0]                 sfr_rdata_o,
  // Decoded SPI commands
  input  wire logic                  spi_valid_i,
  input  wire logic [7:0]            spi_cmd_i,
  input  wire logic [15:0]           spi_addr_i,
  input  wire logic [7:0]            spi_wdata_i,
  output logic                       spi_done_o,
  output logic                       spi_refused_o,
  output logic [7:0]                 spi_rdata_o,
  // MCU code and data accesses
  input  wire logic                  mcu_valid_i,
  input  wire logic                  mcu_wr_i,
  input  wire logic                  mcu_code_i,
  input  wire logic [15:0]           mcu_addr_i,
  input  wire logic [7:0]            mcu_wdata_i,
  output logic                       mcu_done_o,
  output logic                       mcu_refused_o,
  output logic [7:0]                 mcu_rdata_o,
  // OTP array port
  output otpcfg_pkg::otpcfg_arr_req_type arr_o,
  input  wire logic                  arr_ack_i,
  input  wire logic [7:0]            arr_rdata_i,
  // Status view
  output logic                       ready_low_flag_o,
  output logic                       readback_disable_o
);
  import otpcfg_pkg::*;

  // ==========================================
  // State
  otpcfg_state_type   state;
  otpcfg_state_type   next_state;
  otpcfg_arr_req_type arr;
  otpcfg_arr_req_type next_arr;
  logic               wen;
  logic               next_wen;
  logic               ready_low_flag;
  logic               next_ready_low_flag;
  logic               infopage_redirect;
  logic               next_infopage_redirect;
  logic               readback_disable;
  logic               next_readback_disable;
  logic               rsv0;
  logic               next_rsv0;
  logic               spi_done;
  logic               next_spi_done;
  logic               spi_refused;
  logic               next_spi_refused;
  logic [7:0]         spi_rdata;
  logic [7:0]         next_spi_rdata;
  logic               mcu_done;
  logic               next_mcu_done;
  logic               mcu_refused;
  logic               next_mcu_refused;
  logic [7:0]         mcu_rdata;
  logic [7:0]         next_mcu_rdata;
  logic [7:0]         sfr_rdata;
  logic [7:0]         next_sfr_rdata;
  logic [7:0]         status;
  logic               mcu_hit;
  logic [14:0]        mcu_phys;
  logic               spi_main_ok;
  logic [14:0]        spi_phys;
  logic               sfr_hit;

  otpcfg_addr_map u_map (
    .mcu_addr_i    (mcu_addr_i),
    .mcu_code_i    (mcu_code_i),
    .spi_addr_i    (spi_addr_i),
    .mcu_hit_o     (mcu_hit),
    .mcu_phys_o    (mcu_phys),
    .spi_main_ok_o (spi_main_ok),
    .spi_phys_o    (spi_phys)
  );

  // ==========================================
  // Status byte, shared by SPI and MCU
  always_comb begin
    status                        = 8'h00;
    status[`OTPCFG_BIT_WEN]       = wen;
    status[`OTPCFG_BIT_READY_LOW_FLAG]      = ready_low_flag;
    status[`OTPCFG_BIT_REDIR]     = infopage_redirect;
    status[`OTPCFG_BIT_RBD]       = readback_disable;
    status[`OTPCFG_BIT_RSV1]      = 1'b1;
    status[`OTPCFG_BIT_RSV0]      = rsv0;
  end

  assign sfr_hit = (sfr_addr_i == `OTPCFG_STATUS_ADDR); // R10

  // ==========================================
  // Next-state logic
  always_comb begin
    next_state             = state;
    next_arr               = arr;
    next_wen               = wen;
    next_ready_low_flag    = ready_low_flag;
    next_infopage_redirect = infopage_redirect;
    next_readback_disable  = readback_disable;
    next_rsv0              = rsv0;
    next_spi_done          = 1'b0;
    next_spi_refused       = 1'b0;
    next_spi_rdata         = spi_rdata;
    next_mcu_done          = 1'b0;
    next_mcu_refused       = 1'b0;
    next_mcu_rdata         = mcu_rdata;
    next_sfr_rdata         = sfr_hit ? status : 8'h00;
    case (state)
      OTPCFG_BOOT_REQ: begin
        // Fetch the protect byte before anything else may touch the array
        next_arr = '{req: 1'b1, wr: 1'b0, info: 1'b1,
                     addr: `OTPCFG_IP_RBD_OFS, wdata: 8'h00}; // R4
        next_state = OTPCFG_BOOT_WAIT;
      end
      OTPCFG_BOOT_WAIT: begin
        if (arr_ack_i) begin
          next_arr.req          = 1'b0;
          next_readback_disable = (arr_rdata_i != `OTPCFG_RBD_OPEN); // R8 R14
          next_ready_low_flag   = 1'b0; // R12
          next_state            = OTPCFG_IDLE;
        end
      end
      OTPCFG_IDLE: begin
        // Requesters drop valid in the cycle done is seen; the guard stops a retake
        if (spi_valid_i && !spi_done) begin
          case (spi_cmd_i)
            `OTPCFG_CMD_LATCH_SET: begin
              next_wen      = 1'b1; // R19
              next_spi_done = 1'b1;
            end
            `OTPCFG_CMD_LATCH_CLEAR: begin
              next_wen      = 1'b0; // R19
              next_spi_done = 1'b1;
            end
            `OTPCFG_CMD_STAT_READ: begin
              next_spi_rdata = status; // R10
              next_spi_done  = 1'b1;
            end
            `OTPCFG_CMD_STAT_WRITE: begin
              // Only the redirect bit is open to this command
              next_infopage_redirect = spi_wdata_i[`OTPCFG_BIT_REDIR]; // R13 R15
              next_spi_done          = 1'b1;
            end
            `OTPCFG_CMD_READ: begin
              if (infopage_redirect || (!readback_disable && spi_main_ok)) begin // R8 R13 R20
                next_arr = '{req: 1'b1, wr: 1'b0, info: infopage_redirect,
                             addr: spi_phys, wdata: 8'h00};
                next_state = OTPCFG_SPI_WAIT;
              end else begin
                next_spi_done    = 1'b1;
                next_spi_refused = 1'b1;
              end
            end
            `OTPCFG_CMD_PROGRAM: begin
              if (wen && !readback_disable && (infopage_redirect || spi_main_ok)) begin // R11 R14
                next_arr = '{req: 1'b1, wr: 1'b1, info: infopage_redirect,
                             addr: spi_phys, wdata: spi_wdata_i};
                next_state = OTPCFG_SPI_WAIT;
              end else begin
                next_spi_done    = 1'b1;
                next_spi_refused = 1'b1;
              end
            end
            `OTPCFG_CMD_RBD: begin
              if (wen) begin // R18
                next_arr = '{req: 1'b1, wr: 1'b1, info: 1'b1,
                             addr: `OTPCFG_IP_RBD_OFS, wdata: `OTPCFG_RBD_CLOSED};
                next_state = OTPCFG_RBD_WAIT;
              end else begin
                next_spi_done    = 1'b1;
                next_spi_refused = 1'b1;
              end
            end
            default: begin
              next_spi_done    = 1'b1;
              next_spi_refused = 1'b1;
            end
          endcase
        end else if (mcu_valid_i && !mcu_done) begin
          // MCU is internal, so the protect byte does not limit it
          if (mcu_hit && (!mcu_wr_i || wen)) begin // R17
            next_arr = '{req: 1'b1, wr: mcu_wr_i, info: 1'b0,
                         addr: mcu_phys, wdata: mcu_wdata_i};
            next_state = OTPCFG_MCU_WAIT;
          end else begin
            next_mcu_done    = 1'b1;
            next_mcu_refused = 1'b1;
          end
        end
      end
      OTPCFG_SPI_WAIT: begin
        if (arr_ack_i) begin
          next_arr.req   = 1'b0;
          next_spi_rdata = arr_rdata_i;
          next_spi_done  = 1'b1;
          if (arr.wr) begin
            next_wen = 1'b0; // R11
          end
          next_state = OTPCFG_IDLE;
        end
      end
      OTPCFG_RBD_WAIT: begin
        if (arr_ack_i) begin
          next_arr.req          = 1'b0;
          next_readback_disable = 1'b1; // R18
          next_wen              = 1'b0; // R11
          next_spi_done         = 1'b1;
          next_state            = OTPCFG_IDLE;
        end
      end
      OTPCFG_MCU_WAIT: begin
        // Latch stays set after MCU writes
        if (arr_ack_i) begin
          next_arr.req   = 1'b0;
          next_mcu_rdata = arr_rdata_i;
          next_mcu_done  = 1'b1;
          next_state     = OTPCFG_IDLE;
        end
      end
      default: begin
        next_state = OTPCFG_BOOT_REQ;
      end
    endcase
    // MCU write to the status register; its latch value wins over any SPI change of the latch
    if (sfr_wr_i && sfr_hit) begin
      next_wen               = sfr_wdata_i[`OTPCFG_BIT_WEN]; // R11
      next_infopage_redirect = sfr_wdata_i[`OTPCFG_BIT_REDIR]; // R13
      next_rsv0              = sfr_wdata_i[`OTPCFG_BIT_RSV0];
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state             <= OTPCFG_BOOT_REQ;
      arr               <= '0;
      wen               <= 1'b0; // R11
      ready_low_flag    <= 1'b1; // R12
      infopage_redirect <= 1'b0; // R13
      readback_disable  <= 1'b1; // R14 R20
      rsv0              <= 1'b0;
      spi_done          <= 1'b0;
      spi_refused       <= 1'b0;
      spi_rdata         <= 8'h00;
      mcu_done          <= 1'b0;
      mcu_refused       <= 1'b0;
      mcu_rdata         <= 8'h00;
      sfr_rdata         <= 8'h00;
    end else begin
      state             <= next_state;
      arr               <= next_arr;
      wen               <= next_wen;
      ready_low_flag    <= next_ready_low_flag;
      infopage_redirect <= next_infopage_redirect;
      readback_disable  <= next_readback_disable;
      rsv0              <= next_rsv0;
      spi_done          <= next_spi_done;
      spi_refused       <= next_spi_refused;
      spi_rdata         <= next_spi_rdata;
      mcu_done          <= next_mcu_done;
      mcu_refused       <= next_mcu_refused;
      mcu_rdata         <= next_mcu_rdata;
      sfr_rdata         <= next_sfr_rdata;
    end
  end

  // ==========================================
  // Outputs straight from flip-flops
  assign arr_o              = arr;
  assign sfr_rdata_o        = sfr_rdata;
  assign spi_done_o         = spi_done;
  assign spi_refused_o      = spi_refused;
  assign spi_rdata_o        = spi_rdata;
  assign mcu_done_o         = mcu_done;
  assign mcu_refused_o      = mcu_refused;
  assign mcu_rdata_o        = mcu_rdata;
  assign ready_low_flag_o   = ready_low_flag;
  assign readback_disable_o = readback_disable;
endmodule
`default_nettype wire

// ==== verification/otpcfg_arr_model.sv ====
// Behavioural OTP array that answers the block's array port
`timescale 1ns/1ps
`default_nettype none
module otpcfg_arr_model (
  // Clock and reset
  input  wire logic                           ref_clk_i,
  input  wire logic                           resetn_i,
  // Answer speed
  input  wire logic                           slow_i,
  // Array port
  input  wire otpcfg_pkg::otpcfg_arr_req_type arr_i,
  output logic                                ack_o,
  output logic [7:0]                          rdata_o
);
  import otpcfg_pkg::*;
  // ==========================================
  // Storage: info page in the upper half, main block below
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic [1:0] wait_cnt;
  initial begin
    // Erased cells read 0xFF, so the lock byte starts open
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    last = 8'h00;
  end
  // Data is only valid with the ack; otherwise show a wrong value
  assign rdata_o = ack_o ? last : ~last;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= 1'h0;
      wait_cnt <= 2'h0;
    end else begin
      ack_o <= 1'h0;
      if (arr_i.req && !ack_o && wait_cnt < {slow_i, slow_i}) begin
        wait_cnt <= wait_cnt + 2'h1;
      end else if (arr_i.req && !ack_o) begin
        ack_o <= 1'h1;
        wait_cnt <= 2'h0;
        // Cells survive reset, so a lock written once shows at every boot
        if (arr_i.wr)
          mem[{arr_i.info, arr_i.addr}] <= arr_i.wdata;
        else
          last <= mem[{arr_i.info, arr_i.addr}];
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/otpcfg_chk.sv ====
// Port-level assertions for the OTP configuration block
`timescale 1ns/1ps
`default_nettype none
module otpcfg_chk (
  // Clock and reset
  input wire logic                           ref_clk_i,
  input wire logic                           resetn_i,
  // Observed ports
  input wire logic [7:0]                     sfr_addr_i,
  input wire logic [7:0]                     sfr_rdata_o,
  input wire logic                           spi_valid_i,
  input wire logic [7:0]                     spi_cmd_i,
  input wire logic                           spi_done_o,
  input wire logic                           spi_refused_o,
  input wire logic                           mcu_valid_i,
  input wire logic                           mcu_code_i,
  input wire logic [15:0]                    mcu_addr_i,
  input wire otpcfg_pkg::otpcfg_arr_req_type arr_o,
  input wire logic                           arr_ack_i,
  input wire logic [7:0]                     arr_rdata_i,
  input wire logic                           ready_low_flag_o,
  input wire logic                           readback_disable_o
);
  import otpcfg_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================
  // Steps
  sequence s_boot_ack;
    ready_low_flag_o && arr_ack_i;
  endsequence
  sequence s_prog_locked;
    spi_valid_i && !spi_done_o && spi_cmd_i == 8'h02 && readback_disable_o && !ready_low_flag_o;
  endsequence
  sequence s_lock_write;
    arr_o.req && arr_o.wr && arr_o.info && arr_o.addr == 15'h0023;
  endsequence
  // ==========================================
  // Assertions
  a_boot_request: assert property ($rose(resetn_i) |=>
    arr_o.req && arr_o.info && !arr_o.wr && arr_o.addr == 15'h0023) else $error("boot read");
  a_locked_early: assert property (ready_low_flag_o |-> readback_disable_o)
    else $error("lock before boot");
  a_boot_load: assert property (s_boot_ack |=> !ready_low_flag_o &&
    readback_disable_o == ($past(arr_rdata_i) != 8'hFF)) else $error("boot load");
  a_ready_holds: assert property (!ready_low_flag_o |=> !ready_low_flag_o)
    else $error("ready lost");
  a_prog_refused: assert property (s_prog_locked |-> ##[1:12]
    (spi_done_o && spi_refused_o)) else $error("locked program");
  a_lock_zero: assert property (s_lock_write and !ready_low_flag_o |->
    arr_o.wdata == 8'h00) else $error("lock value");
  a_lock_sets: assert property (s_lock_write and arr_ack_i |-> ##[1:2] readback_disable_o)
    else $error("lock flag");
  a_nv_map: assert property (mcu_valid_i && !spi_valid_i && !mcu_code_i &&
    mcu_addr_i >= 16'hFC00 && arr_o.req |->
    !arr_o.info && arr_o.addr == 15'h4400 + {5'h00, mcu_addr_i[9:0]}) else $error("nv map");
  a_code_map: assert property (mcu_valid_i && !spi_valid_i && mcu_code_i && arr_o.req |->
    !arr_o.info && arr_o.addr == {1'h0, mcu_addr_i[13:0]}) else $error("code map");
  a_sfr_other: assert property (sfr_addr_i != 8'hF8 |=> sfr_rdata_o == 8'h00)
    else $error("unmapped sfr");
  a_sfr_fixed: assert property (sfr_addr_i == 8'hF8 |=>
    sfr_rdata_o[7:6] == 2'h0 && sfr_rdata_o[1]) else $error("fixed bits");
endmodule
bind otpcfg_ctrl otpcfg_chk i_otpcfg_chk (.*);
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the OTP configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s: expected %h seen %h", n, e, g); end end
module testbench;
  import otpcfg_pkg::*;
  typedef struct packed {
    logic [1:0] k;  // 0 spi, 1 mcu, 2 sfr write, 3 sfr read
    logic [7:0] c;  // spi command, or mcu {wr, code}
    logic [15:0] a;
    logic [7:0] d;
    logic r;
    logic ck;
    logic [7:0] e;
  } otpcfg_row_type;
  logic ref_clk_i = 1'h0, resetn_i = 1'h0, sfr_wr_i = 1'h0, spi_valid_i = 1'h0;
  logic mcu_valid_i = 1'h0, mcu_wr_i = 1'h0, mcu_code_i = 1'h0, slow = 1'h0, rf;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, spi_cmd_i = 8'h00;
  logic [7:0] spi_wdata_i = 8'h00, mcu_wdata_i = 8'h00, rd;
  logic [15:0] spi_addr_i = 16'h0000, mcu_addr_i = 16'h0000;
  logic spi_done_o, spi_refused_o, mcu_done_o, mcu_refused_o, arr_ack_i;
  logic ready_low_flag_o, readback_disable_o;
  logic [7:0] sfr_rdata_o, spi_rdata_o, mcu_rdata_o, arr_rdata_i;
  otpcfg_arr_req_type arr_o;
  int fail_count = 0, checks_done = 0;
  otpcfg_ctrl i_otpcfg_ctrl (.*);
  otpcfg_arr_model i_otpcfg_arr_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .slow_i(slow), .arr_i(arr_o), .ack_o(arr_ack_i), .rdata_o(arr_rdata_i));
  always #4 ref_clk_i = ~ref_clk_i;
  // ==========================================
  // Ordinary cases; the lock byte and the device area are never written here
  otpcfg_row_type rows [28] = '{
    '{2'h0, 8'h05, 16'h0000, 8'h00, 1'h0, 1'h1, 8'h02},
    '{2'h0, 8'h02, 16'h0010, 8'h5A, 1'h1, 1'h0, 8'h00},
    '{2'h0, 8'h06, 16'h0000, 8'h00, 1'h0, 1'h0, 8'h00},
    '{2'h0, 8'h05, 16'h0000, 8'h00, 1'h0, 1'h1, 8'h22},
    '{2'h0, 8'h02, 16'h0010, 8'h5A, 1'h0, 1'h0, 8'h00},
    '{2'h0, 8'h05, 16'h0000, 8'h00, 1'h0, 1'h1, 8'h02},
    '{2'h0, 8'h03, 16'h0010, 8'h00, 1'h0, 1'h1, 8'h5A},
    '{2'h0, 8'h03, 16'h4800, 8'h00, 1'h1, 1'h0, 8'h00},
    '{2'h0, 8'h01, 16'h0000, 8'hFF, 1'h0, 1'h0, 8'h00},
    '{2'h0, 8'h05, 16'h0000, 8'h00, 1'h0, 1'h1, 8'h0A},
    '{2'h0, 8'h03, 16'h0023, 8'h00, 1'h0, 1'h1, 8'hFF},
    '{2'h0, 8'h01, 16'h0000, 8'h00, 1'h0, 1'h0, 8'h00},
    '{2'h0, 8'h06, 16'h0000, 8'h00, 1'h0, 1'h0, 8'h00},
    '{2'h0, 8'h04, 16'h0000, 8'h00, 1'h0, 1'h0, 8'h00},
    '{2'h0, 8'h05, 16'h0000, 8'h00, 1'h0, 1'h1, 8'h02},
    '{2'h0, 8'h85, 16'h0000, 8'h00, 1'h1, 1'h0, 8'h00},
    '{2'h0, 8'hAB, 16'h0000, 8'h00, 1'h1, 1'h0, 8'h00},
    '{2'h1, 8'h02, 16'hFC05, 8'h33, 1'h1, 1'h0, 8'h00},
    '{2'h2, 8'h00, 16'h00F8, 8'h20, 1'h0, 1'h0, 8'h00},
    '{2'h1, 8'h02, 16'hFC05, 8'h33, 1'h0, 1'h0, 8'h00},
    '{2'h3, 8'h00, 16'h00F8, 8'h00, 1'h0, 1'h1, 8'h22},
    '{2'h1, 8'h00, 16'hFC05, 8'h00, 1'h0, 1'h1, 8'h33},
    '{2'h0, 8'h03, 16'h4405, 8'h00, 1'h0, 1'h1, 8'h33},
    '{2'h1, 8'h01, 16'h0010, 8'h00, 1'h0, 1'h1, 8'h5A},
    '{2'h1, 8'h00, 16'h8000, 8'h00, 1'h1, 1'h0, 8'h00},
    '{2'h2, 8'h00, 16'h00F8, 8'h2D, 1'h0, 1'h0, 8'h00},
    '{2'h3, 8'h00, 16'h00F8, 8'h00, 1'h0, 1'h1, 8'h2B},
    '{2'h2, 8'h00, 16'h00F8, 8'h00, 1'h0, 1'h0, 8'h00}};
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One transfer; requests stay up until the done pulse is seen
  task automatic xfer(input otpcfg_row_type r);
    int n;
    n = 0;
    {spi_cmd_i, spi_addr_i, spi_wdata_i} = {r.c, r.a, r.d};
    {mcu_wr_i, mcu_code_i, mcu_addr_i, mcu_wdata_i} = {r.c[1:0], r.a, r.d};
    {sfr_addr_i, sfr_wdata_i} = {r.a[7:0], r.d};
    spi_valid_i = (r.k == 2'h0);
    mcu_valid_i = (r.k == 2'h1);
    sfr_wr_i = (r.k == 2'h2);
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while (r.k < 2'h2 && (r.k[0] ? mcu_done_o : spi_done_o) !== 1'h1 && n < 40);
    rf = r.k[0] ? mcu_refused_o : spi_refused_o;
    rd = r.k == 2'h0 ? spi_rdata_o : r.k == 2'h1 ? mcu_rdata_o : sfr_rdata_o;
    {spi_valid_i, mcu_valid_i, sfr_wr_i} = 3'h0;
    if (n >= 40)
      fail_count++;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic sp(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    xfer('{2'h0, c, a, d, 1'h0, 1'h0, 8'h00});
  endtask
  task automatic boot;
    int n;
    n = 0;
    resetn_i = 1'h1;
    while (ready_low_flag_o !== 1'h0 && n < 40) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n >= 40)
      fail_count++;
  endtask
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    #1;
    `CHK("ready in reset", 1'h1, ready_low_flag_o)
    `CHK("lock in reset", 1'h1, readback_disable_o)
    boot();
    `CHK("lock open", 1'h0, readback_disable_o)
    for (int i = 0; i < 28; i++) begin
      xfer(rows[i]);
      if (rows[i].k < 2'h2) `CHK("refused", rows[i].r, rf)
      if (rows[i].ck) `CHK("data", rows[i].e, rd)
    end
    $display("table tests done");
    // ==========================================
    // Locking, then commands after the lock (latch, status write, info read, refused program), issued slowly answered
    slow = 1'h1;
    sp(8'h06, 16'h0000, 8'h00);
    sp(8'h85, 16'h0000, 8'h00);
    `CHK("lock taken", 1'h0, rf)
    sp(8'h05, 16'h0000, 8'h00);
    `CHK("locked status", 8'h06, rd)
    sp(8'h03, 16'h0010, 8'h00);
    `CHK("main read", 1'h1, rf)
    sp(8'h06, 16'h0000, 8'h00);
    sp(8'h01, 16'h0000, 8'h08);
    sp(8'h03, 16'h0023, 8'h00);
    `CHK("info read", 8'h00, rd)
    sp(8'h02, 16'h0100, 8'h11);
    `CHK("info write", 1'h1, rf)
    xfer('{2'h1, 8'h00, 16'hFC05, 8'h00, 1'h0, 1'h0, 8'h00});
    `CHK("mcu data", 8'h33, rd)
    $display("lock tests done");
    resetn_i = 1'h0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK("ready again", 1'h1, ready_low_flag_o)
    boot();
    `CHK("lock kept", 1'h1, readback_disable_o)
    xfer('{2'h3, 8'h00, 16'h00F8, 8'h00, 1'h0, 1'h0, 8'h00});
    `CHK("status reloaded", 8'h06, rd)
    $display("reset tests done");
    report_and_stop();
  end
endmodule
`default_nettype wire
